// file: rtl/swc_pkg.sv
// Constants, field positions and types shared by both ends of the snooze wake control link
// Overview of operation
// - Hardware trigger during stop starts conversion autonomously
// - Snooze uses one-shot hardware-trigger-wait modes only
// - Arm snooze only with high-speed oscillator clock
// - Set snooze wake enable just before stop (code sets it in the same cycle as stop)
// - Set power enable after all settings (code sets it one cycle before snooze wake enable)
// - Grant clock, wait stabilization, then convert
// - Second mode register takes only two values
// - Trigger source is the interval timer interrupt
// - With check select clear, in-range result raises conversion end interrupt
// - With check select clear, out-of-range result raises no interrupt
// - Suppressed interrupt leaves stored result unchanged
// - Select mode interrupt returns to normal operation
// - Software clears snooze wake enable after wake
// - Scan mode hit keeps clock request high
// - Select mode miss drops clock request
// - Scan miss drops request after fourth channel
// - After a miss, return to stop and repeat
// - Temperature sensor or reference only in high-speed mode
// - Result codes have ten-bit resolution
// - One-shot end clears conversion-in-progress, converter stops
// - Scan converts four channels from first slot
package swc_pkg;
    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int STAB_TIME_NS    = 1000;
    localparam int CONV_TIME_NS    = 2000;
    localparam int STAB_CYCLES     = (STAB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CONV_CYCLES     = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TIMER_PERIOD    = 1000;
    localparam int CNT_W           = 16;
    // -------------------------------------------------------------------------
    // Register fields
    // -------------------------------------------------------------------------
    localparam int RES_W           = 10;
    localparam int CH_W            = 5;
    localparam int POWER_EN_BIT    = 0;
    localparam int SCAN_MODE_BIT   = 6;
    localparam int SNOOZE_WAKE_BIT = 2;
    localparam int CHECK_SEL_BIT   = 3;
    localparam int SCAN_SLOTS      = 4;
    localparam logic [7:0] MODE_B_SELECT_VAL = 8'he2;
    localparam logic [7:0] MODE_B_ALT_VAL    = 8'he3;
    localparam logic [1:0] TRIG_SEL_TIMER_A  = 2'h2;
    localparam logic [1:0] TRIG_SEL_TIMER_B  = 2'h3;
    localparam logic [4:0] CH_TEMP_SENSOR    = 5'h10;
    localparam logic [4:0] CH_INT_REF        = 5'h11;
    localparam logic [7:0] MODE_RESET        = 8'h00;
    localparam logic [7:0] LIMIT_UPPER_RESET = 8'hff;
    localparam logic [7:0] LIMIT_LOWER_RESET = 8'h00;

    typedef enum logic [2:0] {
        SWC_IDLE,
        SWC_GRANT,
        SWC_STAB,
        SWC_CONV,
        SWC_CHECK,
        SWC_WAKE
    } swc_dev_state_t;

    typedef enum logic [1:0] {
        SWC_RUN,
        SWC_CFG,
        SWC_PWR,
        SWC_SLEEP
    } swc_ctl_state_t;
endpackage

// file: rtl/swc_link_if.sv
// Interface joining the converter snooze end and the system control end
`timescale 1ns/1ps
`default_nettype none
interface swc_link_if;
    // Configuration images written by the control end
    logic [7:0] converter_mode_reg_a;
    logic [7:0] converter_mode_reg_b;
    logic [7:0] converter_mode_reg_c;
    logic [4:0] channel_select_reg;
    logic [7:0] result_upper_limit;
    logic [7:0] result_lower_limit;
    logic       stop_state;
    logic       interval_timer_irq;
    logic       clock_grant;
    // Status from the converter end
    logic       clock_request;
    logic       conversion_end_irq;
    logic [9:0] conversion_result;
    logic       conversion_in_progress;
    logic       wake;

    modport dev (
        input  converter_mode_reg_a, converter_mode_reg_b, converter_mode_reg_c,
        input  channel_select_reg, result_upper_limit, result_lower_limit,
        input  stop_state, interval_timer_irq, clock_grant,
        output clock_request, conversion_end_irq, conversion_result,
        output conversion_in_progress, wake
    );
    modport ctl (
        output converter_mode_reg_a, converter_mode_reg_b, converter_mode_reg_c,
        output channel_select_reg, result_upper_limit, result_lower_limit,
        output stop_state, interval_timer_irq, clock_grant,
        input  clock_request, conversion_end_irq, conversion_result,
        input  conversion_in_progress, wake
    );
endinterface
`default_nettype wire

// file: rtl/swc_dev.sv
// Converter end: snooze trigger, clock request, stabilization, conversion and window check
`timescale 1ns/1ps
`default_nettype none
module swc_dev #(
    parameter int STAB_CYCLES = swc_pkg::STAB_CYCLES,
    parameter int CONV_CYCLES = swc_pkg::CONV_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    swc_link_if.dev         link,

    // Analog front end
    output logic [4:0]      analog_channel,
    output logic            sample_strobe,
    input  wire logic [9:0] analog_code
);
    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    typedef struct packed {
        swc_pkg::swc_dev_state_t     state;
        logic [swc_pkg::CNT_W-1:0]   cnt;
        logic [1:0]                  slot;
        logic                        hit;

        logic                        clock_request;
        logic                        irq;
        logic [swc_pkg::RES_W-1:0]   result;

        logic                        busy;
        logic                        wake;

        logic [swc_pkg::CH_W-1:0]    channel;
        logic                        strobe;
    } swc_dev_reg_t;

    swc_dev_reg_t r;
    swc_dev_reg_t next_r;

    // -------------------------------------------------------------------------
    // Decoded configuration
    // -------------------------------------------------------------------------
    logic       power_en;
    logic       snooze_en;
    logic       scan_mode;
    logic       check_sel;

    logic       trig_is_timer;
    logic       trigger;

    logic [7:0] code_top;
    logic       in_window;
    logic       irq_ok;
    logic       last_slot;

    assign power_en  = link.converter_mode_reg_a[swc_pkg::POWER_EN_BIT];
    assign scan_mode = link.converter_mode_reg_a[swc_pkg::SCAN_MODE_BIT];

    assign snooze_en = link.converter_mode_reg_c[swc_pkg::SNOOZE_WAKE_BIT];
    assign check_sel = link.converter_mode_reg_c[swc_pkg::CHECK_SEL_BIT];

    // Only the interval timer interrupt can start a snooze conversion
    assign trig_is_timer = (link.converter_mode_reg_b[1:0] == swc_pkg::TRIG_SEL_TIMER_A)
                        || (link.converter_mode_reg_b[1:0] == swc_pkg::TRIG_SEL_TIMER_B);

    assign trigger = link.interval_timer_irq && trig_is_timer && power_en;

    // Window compare on the upper eight of the ten result bits
    assign code_top  = analog_code[swc_pkg::RES_W-1:2];
    assign in_window = (code_top >= link.result_lower_limit) && (code_top <= link.result_upper_limit);
    // Select bit chooses whether inside or outside the limits counts as a hit
    assign irq_ok    = check_sel ? !in_window : in_window;

    assign last_slot = !scan_mode || (r.slot == 2'(swc_pkg::SCAN_SLOTS - 1));

    // -------------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------------
    always_comb begin
        next_r        = r;

        next_r.irq    = 1'b0;
        next_r.wake   = 1'b0;
        next_r.strobe = 1'b0;

        case (r.state)
            // Stop state with snooze armed: wait for the timer trigger
            swc_pkg::SWC_IDLE: begin
                next_r.clock_request = 1'b0;
                if (link.stop_state && snooze_en && trigger) begin
                    next_r.clock_request = 1'b1;
                    next_r.busy          = 1'b1;
                    next_r.slot          = 2'h0;
                    next_r.hit           = 1'b0;
                    next_r.state         = swc_pkg::SWC_GRANT;
                end
            end

            // Oscillator requested; nothing counts until it is granted
            swc_pkg::SWC_GRANT: begin
                if (link.clock_grant) begin
                    next_r.cnt   = swc_pkg::CNT_W'(STAB_CYCLES - 1);
                    next_r.state = swc_pkg::SWC_STAB;
                end
            end

            // Full stabilization count must expire before any sampling
            swc_pkg::SWC_STAB: begin
                if (r.cnt == '0) begin
                    next_r.cnt     = swc_pkg::CNT_W'(CONV_CYCLES - 1);
                    next_r.channel = link.channel_select_reg;
                    next_r.strobe  = 1'b1;
                    next_r.state   = swc_pkg::SWC_CONV;
                end else begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end

            // Conversion time runs out; a new trigger restarts from slot zero
            swc_pkg::SWC_CONV: begin
                if (trigger) begin
                    next_r.slot    = 2'h0;
                    next_r.hit     = 1'b0;
                    next_r.channel = link.channel_select_reg;
                    next_r.strobe  = 1'b1;
                    next_r.cnt     = swc_pkg::CNT_W'(CONV_CYCLES - 1);
                end else if (r.cnt == '0) begin
                    next_r.state = swc_pkg::SWC_CHECK;
                end else begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end

            // Judge the code, store only on a hit
            swc_pkg::SWC_CHECK: begin
                if (irq_ok) begin
                    next_r.irq    = 1'b1;
                    next_r.result = analog_code;
                    next_r.hit    = 1'b1;
                end

                if (!last_slot) begin
                    // Scan walks the four slots in order from the first
                    next_r.slot    = r.slot + 2'h1;
                    next_r.channel = r.channel + 5'h01;
                    next_r.strobe  = 1'b1;
                    next_r.cnt     = swc_pkg::CNT_W'(CONV_CYCLES - 1);
                    next_r.state   = swc_pkg::SWC_CONV;
                end else begin
                    next_r.busy = 1'b0;
                    if (irq_ok || r.hit) begin
                        // Keep the oscillator and hand over to normal operation
                        next_r.clock_request = 1'b1;
                        next_r.wake          = 1'b1;
                        next_r.state         = swc_pkg::SWC_WAKE;
                    end else begin
                        // No hit anywhere: release the clock and sleep again
                        next_r.clock_request = 1'b0;
                        next_r.state         = swc_pkg::SWC_IDLE;
                    end
                end
            end

            // Normal operation until software drops the snooze enable
            swc_pkg::SWC_WAKE: begin
                if (!snooze_en) begin
                    next_r.clock_request = 1'b0;
                    next_r.state         = swc_pkg::SWC_IDLE;
                end
            end

            default: begin
                next_r.state = swc_pkg::SWC_IDLE;
            end
        endcase

        // Losing converter power aborts a grant wait, stabilization, conversion or check underway; the wake state is left alone
        if (!power_en && r.state != swc_pkg::SWC_IDLE && r.state != swc_pkg::SWC_WAKE) begin
            next_r.state         = swc_pkg::SWC_IDLE;
            next_r.busy          = 1'b0;
            next_r.clock_request = 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= '{state: swc_pkg::SWC_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // Outputs come straight from the state flops
    assign link.clock_request          = r.clock_request;
    assign link.conversion_end_irq     = r.irq;
    assign link.conversion_result      = r.result;
    assign link.conversion_in_progress = r.busy;
    assign link.wake                   = r.wake;

    assign analog_channel              = r.channel;
    assign sample_strobe               = r.strobe;
endmodule
`default_nettype wire

// file: rtl/swc_ctl.sv
// System control end: configures snooze, drives interval timer and clock grant
`timescale 1ns/1ps
`default_nettype none
module swc_ctl #(
    parameter int TIMER_PERIOD = swc_pkg::TIMER_PERIOD
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    swc_link_if.ctl         link,
    // CPU side request
    input  wire logic       arm_req,
    input  wire logic [7:0] mode_b_value,
    input  wire logic       scan_select,
    input  wire logic [4:0] channel_value,
    input  wire logic [7:0] upper_value,
    input  wire logic [7:0] lower_value,
    input  wire logic       check_select,
    input  wire logic       hs_osc_selected,
    input  wire logic       high_speed_main_mode,
    output logic            armed,
    output logic            arm_refused,
    output logic            woke,
    output logic [9:0]      wake_result
);
    typedef struct packed {
        swc_pkg::swc_ctl_state_t     state;
        logic [7:0]                  mode_a;
        logic [7:0]                  mode_b;
        logic [7:0]                  mode_c;
        logic [4:0]                  channel;
        logic [7:0]                  upper;
        logic [7:0]                  lower;
        logic                        stop;
        logic [swc_pkg::CNT_W-1:0]   tmr;
        logic                        tick;
        logic                        grant;
        logic                        refused;
        logic                        woke;
        logic [9:0]                  result;
    } swc_ctl_reg_t;

    swc_ctl_reg_t r;
    swc_ctl_reg_t next_r;
    logic         cfg_ok;

    // Only legal snooze setups are accepted
    assign cfg_ok = hs_osc_selected
                 && (mode_b_value == swc_pkg::MODE_B_SELECT_VAL
                  || mode_b_value == swc_pkg::MODE_B_ALT_VAL)
                 && (high_speed_main_mode
                  || (channel_value != swc_pkg::CH_TEMP_SENSOR
                   && channel_value != swc_pkg::CH_INT_REF));

    // -------------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------------
    always_comb begin
        next_r         = r;
        next_r.refused = 1'b0;
        next_r.woke    = 1'b0;
        next_r.tick    = 1'b0;
        // Clock controller grants one cycle after the request
        next_r.grant   = link.clock_request;
        case (r.state)
            swc_pkg::SWC_RUN: begin
                if (arm_req && cfg_ok) begin
                    next_r.mode_a = 8'(scan_select) << swc_pkg::SCAN_MODE_BIT;
                    next_r.mode_b = mode_b_value;
                    next_r.mode_c = 8'(check_select) << swc_pkg::CHECK_SEL_BIT;
                    next_r.channel = channel_value;
                    next_r.upper  = upper_value;
                    next_r.lower  = lower_value;
                    next_r.state  = swc_pkg::SWC_CFG;
                end else if (arm_req) begin
                    next_r.refused = 1'b1;
                end
            end
            // Power enable goes on after the mode, channel and limit settings, one cycle before snooze enable
            swc_pkg::SWC_CFG: begin
                next_r.mode_a[swc_pkg::POWER_EN_BIT] = 1'b1;
                next_r.state = swc_pkg::SWC_PWR;
            end
            // Snooze enable set in the same cycle as entering stop
            swc_pkg::SWC_PWR: begin
                next_r.mode_c[swc_pkg::SNOOZE_WAKE_BIT] = 1'b1;
                next_r.stop  = 1'b1;
                next_r.tmr   = '0;
                next_r.state = swc_pkg::SWC_SLEEP;
            end
            // Interval timer keeps firing while asleep
            swc_pkg::SWC_SLEEP: begin
                if (r.tmr == swc_pkg::CNT_W'(TIMER_PERIOD - 1)) begin
                    next_r.tmr  = '0;
                    next_r.tick = 1'b1;
                end else begin
                    next_r.tmr = r.tmr + 1'b1;
                end
                if (link.wake) begin
                    // Release snooze so later conversions start normally
                    next_r.mode_c[swc_pkg::SNOOZE_WAKE_BIT] = 1'b0;
                    next_r.mode_a[swc_pkg::POWER_EN_BIT]    = 1'b0;
                    next_r.stop   = 1'b0;
                    next_r.woke   = 1'b1;
                    next_r.result = link.conversion_result;
                    next_r.state  = swc_pkg::SWC_RUN;
                end
            end
            default: begin
                next_r.state = swc_pkg::SWC_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= '{state: swc_pkg::SWC_RUN, upper: swc_pkg::LIMIT_UPPER_RESET,
                   lower: swc_pkg::LIMIT_LOWER_RESET, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign link.converter_mode_reg_a = r.mode_a;
    assign link.converter_mode_reg_b = r.mode_b;
    assign link.converter_mode_reg_c = r.mode_c;
    assign link.channel_select_reg   = r.channel;
    assign link.result_upper_limit   = r.upper;
    assign link.result_lower_limit   = r.lower;
    assign link.stop_state           = r.stop;
    assign link.interval_timer_irq   = r.tick;
    assign link.clock_grant          = r.grant;
    assign armed                     = r.stop;
    assign arm_refused               = r.refused;
    assign woke                      = r.woke;
    assign wake_result               = r.result;
endmodule
`default_nettype wire

// file: bench/swc_link_checker.sv
// Concurrent checks on the snooze wake link between the two ends
`timescale 1ns/1ps
`default_nettype none
module swc_link_checker (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [7:0] converter_mode_reg_a,
    input wire logic [7:0] converter_mode_reg_b,
    input wire logic [7:0] converter_mode_reg_c,
    input wire logic [7:0] result_upper_limit,
    input wire logic [7:0] result_lower_limit,
    input wire logic       stop_state,
    input wire logic       interval_timer_irq,
    input wire logic       clock_grant,
    input wire logic       clock_request,
    input wire logic       conversion_end_irq,
    input wire logic [9:0] conversion_result,
    input wire logic       conversion_in_progress,
    input wire logic       wake
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    // Window test on the upper eight result bits
    logic in_win;
    logic hit_seen;
    assign in_win = (result_lower_limit <= conversion_result[9:2]) && (conversion_result[9:2] <= result_upper_limit);
    // Remembers a hit within one request, cleared in the cycle after a new request
    always_ff @(posedge core_clk) begin
        if (rst || (clock_request && !clock_grant)) hit_seen <= 1'b0;
        else if (conversion_end_irq) hit_seen <= 1'b1;
    end
    // ------------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------------
    sequence s_trig;
        !clock_request && stop_state && converter_mode_reg_a[0] && converter_mode_reg_c[2]
            && interval_timer_irq && converter_mode_reg_b[1];
    endsequence
    sequence s_release;
        ##[1:2] !converter_mode_reg_c[2] ##[1:3] !clock_request;
    endsequence
    property p_start; s_trig |=> clock_request && conversion_in_progress; endproperty
    property p_stab; $rose(clock_request) |=> clock_grant ##0 (!conversion_end_irq && conversion_in_progress)[*7]; endproperty
    property p_power_off; !converter_mode_reg_a[0] && !clock_request |=> !clock_request; endproperty
    property p_window; conversion_end_irq |-> (converter_mode_reg_c[3] ^ in_win); endproperty
    property p_store; $changed(conversion_result) |-> conversion_end_irq; endproperty
    property p_done; $rose(clock_request) |-> ##[1:60] !conversion_in_progress; endproperty
    property p_miss; $fell(conversion_in_progress) && !hit_seen && !conversion_end_irq |-> ##[0:2] !clock_request; endproperty
    property p_hold; hit_seen && conversion_in_progress |-> clock_request; endproperty
    property p_wake; conversion_end_irq |-> ##[0:40] wake; endproperty
    property p_release; wake |-> s_release; endproperty
    a_start: assert property (p_start) else $error("trigger did not start a request");
    a_stab: assert property (p_stab) else $error("conversion ended inside stabilization");
    a_power_off: assert property (p_power_off) else $error("request without power enable");
    a_window: assert property (p_window) else $error("interrupt disagrees with window");
    a_store: assert property (p_store) else $error("result changed without interrupt");
    a_done: assert property (p_done) else $error("busy flag never cleared");
    a_miss: assert property (p_miss) else $error("request kept after a miss");
    a_hold: assert property (p_hold) else $error("request dropped after a scan hit");
    a_wake: assert property (p_wake) else $error("interrupt without wake");
    a_release: assert property (p_release) else $error("snooze not released after wake");
endmodule
`default_nettype wire

// file: bench/adc_snooze_wake_control_tb.sv
// Self-checking bench joining both ends of the snooze wake link
`timescale 1ns/1ps
`default_nettype none
module adc_snooze_wake_control_tb;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       arm_req = 1'b0;
    logic [7:0] mode_b_value = 8'he2;
    logic       scan_select = 1'b0;
    logic [4:0] channel_value = 5'h00;
    logic [7:0] upper_value = 8'hff;
    logic [7:0] lower_value = 8'h00;
    logic       check_select = 1'b0;
    logic       hs_osc_selected = 1'b1;
    logic       high_speed_main_mode = 1'b0;
    logic [9:0] analog_code = 10'h000;
    logic       armed, arm_refused, woke, sample_strobe;
    logic [9:0] wake_result;
    logic [4:0] analog_channel;
    logic [4:0] ch_log[$];
    int         errors = 0;
    int         comparisons = 0;
    // ------------------------------------------------------------------
    // Both ends, the link and its checker
    // ------------------------------------------------------------------
    swc_link_if swc_link_if_i ();
    swc_dev #(.STAB_CYCLES(3), .CONV_CYCLES(4)) swc_dev_i (.core_clk(core_clk), .rst(rst), .link(swc_link_if_i),
        .analog_channel(analog_channel), .sample_strobe(sample_strobe), .analog_code(analog_code));
    swc_ctl #(.TIMER_PERIOD(20)) swc_ctl_i (.core_clk(core_clk), .rst(rst), .link(swc_link_if_i), .arm_req(arm_req),
        .mode_b_value(mode_b_value), .scan_select(scan_select), .channel_value(channel_value),
        .upper_value(upper_value), .lower_value(lower_value), .check_select(check_select),
        .hs_osc_selected(hs_osc_selected), .high_speed_main_mode(high_speed_main_mode), .armed(armed),
        .arm_refused(arm_refused), .woke(woke), .wake_result(wake_result));
    swc_link_checker swc_link_checker_i (.core_clk(core_clk), .rst(rst),
        .converter_mode_reg_a(swc_link_if_i.converter_mode_reg_a),
        .converter_mode_reg_b(swc_link_if_i.converter_mode_reg_b),
        .converter_mode_reg_c(swc_link_if_i.converter_mode_reg_c),
        .result_upper_limit(swc_link_if_i.result_upper_limit),
        .result_lower_limit(swc_link_if_i.result_lower_limit), .stop_state(swc_link_if_i.stop_state),
        .interval_timer_irq(swc_link_if_i.interval_timer_irq), .clock_grant(swc_link_if_i.clock_grant),
        .clock_request(swc_link_if_i.clock_request), .conversion_end_irq(swc_link_if_i.conversion_end_irq),
        .conversion_result(swc_link_if_i.conversion_result),
        .conversion_in_progress(swc_link_if_i.conversion_in_progress), .wake(swc_link_if_i.wake));
    // Clock and the log of sampled channels
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (sample_strobe) ch_log.push_back(analog_channel);
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Samples one ns after the edge so the design's updates have landed
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask
    task automatic code(input logic [9:0] v);
        @(posedge core_clk);
        analog_code <= v;
    endtask
    // Config order: mode_b, scan, channel, upper, lower, check select
    task automatic arm(input logic [30:0] c, output logic refused);
        @(posedge core_clk);
        {mode_b_value, scan_select, channel_value, upper_value, lower_value, check_select} <= c;
        arm_req <= 1'b1;
        @(posedge core_clk);
        arm_req <= 1'b0;
        #1;
        refused = arm_refused;
        for (int i = 0; i < 8 && !armed && !refused; i++) begin
            tick();
            refused = arm_refused;
        end
    endtask
    // One whole request round, bounded on both waits
    task automatic round;
        for (int i = 0; i < 60 && !swc_link_if_i.clock_request; i++) tick();
        for (int i = 0; i < 80 && swc_link_if_i.clock_request; i++) tick();
    endtask
    task automatic await_wake;
        for (int i = 0; i < 120 && !woke; i++) tick();
        check(woke, 1'b1);
        repeat (8) tick();
        check(swc_link_if_i.clock_request, 1'b0);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_refuse;
        logic       r;
        logic [7:0] mb[4] = '{8'he2, 8'h80, 8'he3, 8'he2};
        logic [4:0] ch[4] = '{5'h03, 5'h03, 5'h10, 5'h11};
        for (int k = 0; k < 4; k++) begin
            hs_osc_selected <= (k != 0);
            arm({mb[k], 1'b0, ch[k], 8'hff, 8'h00, 1'b0}, r);
            check(r, 1'b1);
            check(armed, 1'b0);
        end
    endtask
    task automatic t_select;
        logic r;
        code(10'h3ff);
        arm({8'he2, 1'b0, 5'h03, 8'h80, 8'h40, 1'b0}, r);
        check(armed, 1'b1);
        round();
        check(swc_link_if_i.conversion_result, 10'h000);
        check(armed, 1'b1);
        check(ch_log[$], 5'h03);
        code(10'h100);
        await_wake();
        check(wake_result, 10'h100);
        check(swc_link_if_i.conversion_result, 10'h100);
    endtask
    // Hit here means outside the window, since check select is set
    task automatic t_scan;
        logic r;
        code(10'h3ff);
        arm({8'he3, 1'b1, 5'h04, 8'hff, 8'h10, 1'b1}, r);
        ch_log.delete();
        round();
        check(ch_log.size(), 16'h0004);
        foreach (ch_log[k]) check(ch_log[k], 5'h04 + k);
        check(swc_link_if_i.conversion_result, 10'h100);
        ch_log.delete();
        code(10'h004);
        await_wake();
        check(ch_log.size(), 16'h0004);
        check(wake_result, 10'h004);
    endtask
    task automatic summarize;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_refuse();
        t_select();
        t_scan();
        summarize();
    end
    // A run of a few hundred cycles is expected; this cuts a hang short
    initial begin
        #40000;
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
